// ===== include/sgoc_pkg.sv
// Behaviour
// - Breaker position codes: 0 between, 1 open, 2 closed, 3 both inputs active.
// - Cart codes: 0 between, 1 out, 2 in, 3 invalid, 4 when not withdrawable.
// - Authority bit resets to remote; the other side's manual requests are refused.
// - With synchrocheck in use, close only while the permission input is high.
// - Ready setting: 0 needs ready high, 1 needs low, 2 ignores it.
// - Object type selects monitored inputs and controls; cart tracked only when withdrawable.
// - Command on/off and status events carry a one millisecond timestamp.
// - Four cumulative counters: opens, closes, failed opens, failed closes.
// - Remote commands run direct or need a prior select (select before execute).
// - Single-input monitoring derives the closed state from the inverted open input.
// - Force selector 0 to 12 overrides reported function status while forcing enabled.
// - Additional status reports open, close, ready and sync allowed or blocked.
// - Outputs are one open and one close command from local, remote or automatic.
// - Settings are static; software changes them only during setup.
// - Bad or between is declared only after the traverse time, 20 ms steps.
// - Clear command zeroes all four counters and then returns to idle itself.
package sgoc_pkg;

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int unsigned CLK_FREQ_KHZ = 250000;
  localparam int unsigned STAMP_RES_MS = 1;
  localparam int unsigned CYC_PER_MS = CLK_FREQ_KHZ * STAMP_RES_MS;
  localparam int unsigned TRAV_STEP_MS = 20;
  localparam int unsigned TRAV_DEFAULT_MS = 200;
  localparam logic [14:0] TRAV_RST = 15'(TRAV_DEFAULT_MS / TRAV_STEP_MS);
  localparam logic [4:0] TRAV_STEP = 5'(TRAV_STEP_MS);
  localparam int unsigned CMD_PULSE_MS = 100;
  localparam logic [9:0] CMD_PULSE = 10'(CMD_PULSE_MS);

  // ---------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_TRAV = 8'h04;
  localparam logic [7:0] ADR_STAT = 8'h08;
  localparam logic [7:0] ADR_CMD = 8'h0C;
  localparam logic [7:0] ADR_IST = 8'h10;
  localparam logic [7:0] ADR_IMASK = 8'h14;
  localparam logic [7:0] ADR_CNT_OPEN = 8'h18;
  localparam logic [7:0] ADR_CNT_CLOSE = 8'h1C;
  localparam logic [7:0] ADR_CNT_OFAIL = 8'h20;
  localparam logic [7:0] ADR_CNT_CFAIL = 8'h24;
  localparam logic [7:0] ADR_STAMP = 8'h28;
  localparam logic [7:0] ADR_EV_CODE = 8'h2C;
  localparam logic [7:0] ADR_EV_TIME = 8'h30;

  localparam int CTL_LR = 0;
  localparam int CTL_TYPE = 1;
  localparam int CTL_SYNC = 3;
  localparam int CTL_RDY = 4;
  localparam int CTL_SINGLE = 6;
  localparam int CTL_FORCE = 7;
  localparam int CTL_FSEL = 8;
  localparam int CTL_SBE = 12;
  localparam logic [12:0] CTRL_RST = 13'h0023;

  localparam int CMD_OPEN = 0;
  localparam int CMD_CLOSE = 1;
  localparam int CMD_SELO = 2;
  localparam int CMD_SELC = 3;
  localparam int CMD_CANCEL = 4;
  localparam int CMD_CLEAR = 8;

  localparam int EV_OPEN_ON = 0;
  localparam int EV_OPEN_OFF = 1;
  localparam int EV_CLOSE_ON = 2;
  localparam int EV_CLOSE_OFF = 3;
  localparam int EV_BKR = 4;
  localparam int EV_CART = 5;
  localparam int EV_OPEN_FAIL = 6;
  localparam int EV_CLOSE_FAIL = 7;
  localparam int NUM_EV = 8;

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    POS_MID = 2'b00, POS_OPEN = 2'b01, POS_CLOSED = 2'b10, POS_BAD = 2'b11
  } sgoc_pos_t;
  localparam logic [2:0] CART_UNUSED = 3'h4;

  typedef enum logic [1:0] {
    OBJ_WD_BKR = 2'b00, OBJ_BKR = 2'b01, OBJ_DISC = 2'b10, OBJ_EARTH = 2'b11
  } sgoc_obj_t;

  typedef enum logic [1:0] {
    RDY_HIGH = 2'b00, RDY_LOW = 2'b01, RDY_OFF = 2'b10
  } sgoc_rdy_t;

  typedef enum logic [1:0] {
    CST_IDLE = 2'b00, CST_OPEN = 2'b01, CST_CLOSE = 2'b10
  } sgoc_cst_t;

  localparam logic [3:0] FST_NORMAL = 4'h0;
  localparam logic [3:0] FST_OPEN_SIG = 4'h3;
  localparam logic [3:0] FST_CLOSE_SIG = 4'h4;
  localparam logic [3:0] FST_NOTRDY_FAIL = 4'h7;
  localparam logic [3:0] FST_NOSYNC_FAIL = 4'h8;
  localparam logic [3:0] FST_MAX = 4'hC;

endpackage

// ===== include/sgoc_pos_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sgoc_pos_if;
  logic in_a;
  logic in_b;
  logic tick;
  logic [19:0] limit_ms;
  logic [1:0] code;
  modport dec (input in_a, input in_b, input tick, input limit_ms,
               output code);
  modport ctl (output in_a, output in_b, output tick, output limit_ms,
               input code);
endinterface
`default_nettype wire

// ===== hw/sgoc_pos_decode.sv
`timescale 1ns/1ps
`default_nettype none
module sgoc_pos_decode
  import sgoc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  sgoc_pos_if.dec pos
);

  logic [1:0] raw;
  logic [1:0] code_q;
  logic [19:0] ms_cnt_q;

  assign raw = {pos.in_b, pos.in_a};
  assign pos.code = code_q;

  // A clean end position is taken at once; both or neither inputs active
  // must persist for the traverse time, so a moving contact is not flagged.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      code_q <= POS_MID;
      ms_cnt_q <= '0;
    end else if (raw == POS_OPEN || raw == POS_CLOSED) begin
      code_q <= raw;
      ms_cnt_q <= '0;
    end else if (ms_cnt_q >= pos.limit_ms) begin
      code_q <= raw;
    end else if (pos.tick) begin
      ms_cnt_q <= ms_cnt_q + 20'h00001;
    end
  end

endmodule // sgoc_pos_decode
`default_nettype wire

// ===== hw/sgoc_top.sv
// The address map and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module sgoc_top
  import sgoc_pkg::*;
#(
  parameter int unsigned CYC_MS = CYC_PER_MS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic open_st_i,
  input wire logic close_st_i,
  input wire logic cart_in_i,
  input wire logic cart_out_i,
  input wire logic ready_i,
  input wire logic sync_ok_i,
  input wire logic loc_open_i,
  input wire logic loc_close_i,
  input wire logic open_blk_i,
  input wire logic close_blk_i,
  input wire logic auto_open_i,
  input wire logic auto_close_i,
  output logic open_cmd_o,
  output logic close_cmd_o,
  output logic irq_o
);

  // -----------------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------------
  function automatic logic [31:0] wb_merge(input logic [31:0] old,
                                           input logic [31:0] wdat,
                                           input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = wdat[8*i +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [31:0] cnt_step(input logic [31:0] cnt,
                                           input logic clr,
                                           input logic inc);
    logic [31:0] res;
    res = cnt;
    if (clr) begin
      res = '0;
    end else if (inc) begin
      res = cnt + 32'h0000_0001;
    end
    return res;
  endfunction

  // -----------------------------------------------------------------------
  // Input synchronisers
  // -----------------------------------------------------------------------
  logic [9:0] sy1_q;
  logic [9:0] sy2_q;
  logic [1:0] loc_prev_q;
  logic open_st_s, close_st_s, cart_in_s, cart_out_s, ready_s, sync_s;
  logic open_blk_s, close_blk_s, loc_open_rise, loc_close_rise;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sy1_q <= '0;
      sy2_q <= '0;
      loc_prev_q <= '0;
    end else begin
      sy1_q <= {close_blk_i, open_blk_i, loc_close_i, loc_open_i, sync_ok_i,
                ready_i, cart_out_i, cart_in_i, close_st_i, open_st_i};
      sy2_q <= sy1_q;
      loc_prev_q <= sy2_q[7:6];
    end
  end

  assign {close_blk_s, open_blk_s} = sy2_q[9:8];
  assign {sync_s, ready_s, cart_out_s, cart_in_s} = sy2_q[5:2];
  assign {close_st_s, open_st_s} = sy2_q[1:0];
  assign loc_open_rise = sy2_q[6] & ~loc_prev_q[0];
  assign loc_close_rise = sy2_q[7] & ~loc_prev_q[1];

  // -----------------------------------------------------------------------
  // Millisecond timebase
  // -----------------------------------------------------------------------
  logic [17:0] div_q;
  logic tick_q;
  logic [31:0] stamp_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q <= '0;
      tick_q <= 1'b0;
      stamp_q <= '0;
    end else begin
      tick_q <= (div_q == 18'(CYC_MS - 1));
      div_q <= (div_q == 18'(CYC_MS - 1)) ? '0 : div_q + 18'h00001;
      if (tick_q) begin
        stamp_q <= stamp_q + 32'h0000_0001;
      end
    end
  end

  // -----------------------------------------------------------------------
  // Settings and position decoding
  // -----------------------------------------------------------------------
  logic [12:0] ctrl_q;
  logic [14:0] trav_q;
  logic lr_q, single_q, force_q, sbe_q, sync_use;
  sgoc_obj_t obj_type;
  sgoc_rdy_t rdy_use;
  logic [3:0] force_sel;
  logic [1:0] bkr_code;
  logic [2:0] cart_code;

  // Settings are static by contract; nothing here guards a change mid-command.
  assign lr_q = ctrl_q[CTL_LR];
  assign obj_type = sgoc_obj_t'(ctrl_q[CTL_TYPE +: 2]);
  assign sync_use = ctrl_q[CTL_SYNC];
  assign rdy_use = sgoc_rdy_t'(ctrl_q[CTL_RDY +: 2]);
  assign single_q = ctrl_q[CTL_SINGLE];
  assign force_q = ctrl_q[CTL_FORCE];
  assign force_sel = ctrl_q[CTL_FSEL +: 4];
  assign sbe_q = ctrl_q[CTL_SBE];

  sgoc_pos_if bkr_if ();
  sgoc_pos_if cart_if ();

  assign bkr_if.in_a = open_st_s;
  assign bkr_if.in_b = single_q ? ~open_st_s : close_st_s;
  assign bkr_if.tick = tick_q;
  assign bkr_if.limit_ms = 20'(trav_q * TRAV_STEP);
  assign cart_if.in_a = cart_out_s;
  assign cart_if.in_b = cart_in_s;
  assign cart_if.tick = tick_q;
  assign cart_if.limit_ms = 20'(trav_q * TRAV_STEP);

  sgoc_pos_decode u_bkr (.clk_i(clk_i), .rst_i(rst_i), .pos(bkr_if.dec));
  sgoc_pos_decode u_cart (.clk_i(clk_i), .rst_i(rst_i), .pos(cart_if.dec));

  assign bkr_code = bkr_if.code;
  assign cart_code = (obj_type == OBJ_WD_BKR) ?
                     {1'b0, cart_if.code} : CART_UNUSED;

  // -----------------------------------------------------------------------
  // Request gating
  // -----------------------------------------------------------------------
  logic rem_open, rem_close, sel_open_q, sel_close_q, rem_open_ok, rem_close_ok;
  logic open_try, close_try, open_auth, close_auth, ctl_allowed;
  logic open_allowed, close_allowed, rdy_ok, sync_ok, brk_type;
  logic open_ok, close_ok, open_fail, close_fail, busy;
  logic wr_cmd;
  sgoc_cst_t cst_q;

  assign busy = (cst_q != CST_IDLE);
  assign brk_type = (obj_type == OBJ_WD_BKR) || (obj_type == OBJ_BKR);
  assign ctl_allowed = (obj_type != OBJ_EARTH);
  assign rdy_ok = !brk_type || (rdy_use == RDY_OFF) ||
                  ((rdy_use == RDY_HIGH) && ready_s) ||
                  ((rdy_use == RDY_LOW) && !ready_s);
  assign sync_ok = !brk_type || !sync_use || sync_s;
  assign open_allowed = ctl_allowed && !open_blk_s && !busy;
  assign close_allowed = ctl_allowed && !close_blk_s && !busy;

  assign rem_open = wr_cmd && wb_sel_i[0] && wb_dat_i[CMD_OPEN];
  assign rem_close = wr_cmd && wb_sel_i[0] && wb_dat_i[CMD_CLOSE];
  assign rem_open_ok = rem_open && lr_q && (!sbe_q || sel_open_q);
  assign rem_close_ok = rem_close && lr_q && (!sbe_q || sel_close_q);

  assign open_try = auto_open_i || loc_open_rise || rem_open;
  assign close_try = auto_close_i || loc_close_rise || rem_close;
  assign open_auth = auto_open_i || (loc_open_rise && !lr_q) ||
                     rem_open_ok;
  assign close_auth = auto_close_i || (loc_close_rise && !lr_q) ||
                      rem_close_ok;
  // Open is the safe direction, so it wins a same-cycle race with close.
  assign open_ok = open_try && open_auth && open_allowed;
  assign close_ok = close_try && close_auth && close_allowed && rdy_ok &&
                    sync_ok && !open_ok;
  assign open_fail = open_try && !open_ok;
  assign close_fail = close_try && !close_ok;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_open_q <= 1'b0;
      sel_close_q <= 1'b0;
    end else if (wr_cmd && wb_sel_i[0]) begin
      // A select lives until the next command write that does not repeat it or that carries a cancel.
      sel_open_q <= wb_dat_i[CMD_SELO] && !wb_dat_i[CMD_CANCEL];
      sel_close_q <= wb_dat_i[CMD_SELC] && !wb_dat_i[CMD_CANCEL];
    end
  end

  // -----------------------------------------------------------------------
  // Command output handler
  // -----------------------------------------------------------------------
  logic open_q, close_q, cmd_end;
  logic [9:0] pulse_q;
  logic [3:0] fst_q;

  assign cmd_end = (pulse_q >= CMD_PULSE) ||
                   ((cst_q == CST_OPEN) && (bkr_code == POS_OPEN)) ||
                   ((cst_q == CST_CLOSE) && (bkr_code == POS_CLOSED));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cst_q <= CST_IDLE;
      open_q <= 1'b0;
      close_q <= 1'b0;
      pulse_q <= '0;
    end else begin
      case (cst_q)
        CST_IDLE: begin
          pulse_q <= '0;
          if (open_ok) begin
            cst_q <= CST_OPEN;
            open_q <= 1'b1;
          end else if (close_ok) begin
            cst_q <= CST_CLOSE;
            close_q <= 1'b1;
          end
        end
        CST_OPEN, CST_CLOSE: begin
          if (tick_q) begin
            pulse_q <= pulse_q + 10'h001;
          end
          if (cmd_end) begin
            cst_q <= CST_IDLE;
            open_q <= 1'b0;
            close_q <= 1'b0;
          end
        end
        default: begin
          cst_q <= CST_IDLE;
          open_q <= 1'b0;
          close_q <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fst_q <= FST_NORMAL;
    end else if (open_ok) begin
      fst_q <= FST_OPEN_SIG;
    end else if (close_ok) begin
      fst_q <= FST_CLOSE_SIG;
    end else if (close_try && !rdy_ok) begin
      fst_q <= FST_NOTRDY_FAIL;
    end else if (close_try && !sync_ok) begin
      fst_q <= FST_NOSYNC_FAIL;
    end else if (busy && cmd_end) begin
      fst_q <= FST_NORMAL;
    end
  end

  // -----------------------------------------------------------------------
  // Counters, events and interrupt
  // -----------------------------------------------------------------------
  logic [31:0] cnt_open_q, cnt_close_q, cnt_ofail_q, cnt_cfail_q;
  logic clr_q, irq_q;
  logic [1:0] bkr_prev_q;
  logic [2:0] cart_prev_q;
  logic [NUM_EV-1:0] ev, ist_q, imask_q, ist_clr;
  logic [2:0] ev_code_q;
  logic [31:0] ev_time_q;
  logic [2:0] ev_first;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_open_q <= '0;
      cnt_close_q <= '0;
      cnt_ofail_q <= '0;
      cnt_cfail_q <= '0;
    end else begin
      cnt_open_q <= cnt_step(cnt_open_q, clr_q, open_ok);
      cnt_close_q <= cnt_step(cnt_close_q, clr_q, close_ok);
      cnt_ofail_q <= cnt_step(cnt_ofail_q, clr_q, open_fail);
      cnt_cfail_q <= cnt_step(cnt_cfail_q, clr_q, close_fail);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clr_q <= 1'b0;
    end else begin
      clr_q <= wr_cmd && wb_sel_i[1] && wb_dat_i[CMD_CLEAR];
    end
  end

  assign ev[EV_OPEN_ON] = (cst_q == CST_IDLE) && open_ok;
  assign ev[EV_OPEN_OFF] = (cst_q == CST_OPEN) && cmd_end;
  assign ev[EV_CLOSE_ON] = (cst_q == CST_IDLE) && !open_ok && close_ok;
  assign ev[EV_CLOSE_OFF] = (cst_q == CST_CLOSE) && cmd_end;
  assign ev[EV_BKR] = (bkr_code != bkr_prev_q);
  assign ev[EV_CART] = (cart_code != cart_prev_q);
  assign ev[EV_OPEN_FAIL] = open_fail;
  assign ev[EV_CLOSE_FAIL] = close_fail;

  always_comb begin
    ev_first = '0;
    for (int i = NUM_EV - 1; i >= 0; i--) begin
      if (ev[i]) begin
        ev_first = 3'(i);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bkr_prev_q <= POS_MID;
      cart_prev_q <= CART_UNUSED;
      ev_code_q <= '0;
      ev_time_q <= '0;
    end else begin
      bkr_prev_q <= bkr_code;
      cart_prev_q <= cart_code;
      if (|ev) begin
        ev_code_q <= ev_first;
        ev_time_q <= stamp_q;
      end
    end
  end

  // A new event in the clearing cycle keeps its bit set.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ist_q <= '0;
      irq_q <= 1'b0;
    end else begin
      ist_q <= (ist_q & ~ist_clr) | ev;
      irq_q <= |(ist_q & imask_q);
    end
  end

  // -----------------------------------------------------------------------
  // Wishbone slave
  // -----------------------------------------------------------------------
  logic ack_q, wr_en;
  logic [31:0] rdat_q, rdat;
  logic [3:0] add_info;

  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;
  assign wr_cmd = wr_en && (wb_adr_i == ADR_CMD);
  assign ist_clr = (wr_en && (wb_adr_i == ADR_IST) && wb_sel_i[0]) ?
                   wb_dat_i[NUM_EV-1:0] : '0;
  assign add_info = {sync_ok, rdy_ok, close_allowed, open_allowed};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RST;
      trav_q <= TRAV_RST;
      imask_q <= '0;
    end else if (wr_en) begin
      if (wb_adr_i == ADR_CTRL) begin
        ctrl_q <= 13'(wb_merge(32'(ctrl_q), wb_dat_i, wb_sel_i));
      end
      if (wb_adr_i == ADR_TRAV) begin
        trav_q <= 15'(wb_merge(32'(trav_q), wb_dat_i, wb_sel_i));
      end
      if (wb_adr_i == ADR_IMASK) begin
        imask_q <= NUM_EV'(wb_merge(32'(imask_q), wb_dat_i, wb_sel_i));
      end
    end
  end

  always_comb begin
    rdat = '0;
    case (wb_adr_i)
      ADR_CTRL: rdat = 32'(ctrl_q);
      ADR_TRAV: rdat = 32'(trav_q);
      ADR_STAT: rdat = {16'h0000, (force_q ? force_sel : fst_q),
                        add_info, 3'b000, cart_code, bkr_code};
      ADR_CMD: rdat = {23'h000000, clr_q, 4'h0, sel_close_q,
                       sel_open_q, 2'b00};
      ADR_IST: rdat = 32'(ist_q);
      ADR_IMASK: rdat = 32'(imask_q);
      ADR_CNT_OPEN: rdat = cnt_open_q;
      ADR_CNT_CLOSE: rdat = cnt_close_q;
      ADR_CNT_OFAIL: rdat = cnt_ofail_q;
      ADR_CNT_CFAIL: rdat = cnt_cfail_q;
      ADR_STAMP: rdat = stamp_q;
      ADR_EV_CODE: rdat = 32'(ev_code_q);
      ADR_EV_TIME: rdat = ev_time_q;
      default: rdat = '0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= '0;
    end else begin
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
      rdat_q <= rdat;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign open_cmd_o = open_q;
  assign close_cmd_o = close_q;
  assign irq_o = irq_q;

  // -----------------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_unselected_exec;
    sbe_q && rem_open && !sel_open_q && !auto_open_i && !loc_open_rise;
  endsequence

  a_cmd_exclusive: assert property (!(open_q && close_q))
    else $error("open and close commands active together");
  a_open_authority: assert property ($rose(open_q) |->
    $past(auto_open_i || (loc_open_rise && !lr_q) || (rem_open && lr_q)))
    else $error("open command without authority");
  a_close_sync: assert property ($rose(close_q) |->
    $past(!brk_type || !sync_use || sync_s))
    else $error("close issued without synchrocheck permission");
  a_close_ready: assert property ($rose(close_q) |-> $past(!brk_type ||
    rdy_use == RDY_OFF || (rdy_use == RDY_HIGH && ready_s) ||
    (rdy_use == RDY_LOW && !ready_s)))
    else $error("close issued while object not ready");
  a_sbe_select: assert property (s_unselected_exec |=> !$rose(open_q))
    else $error("remote open executed without select");
  a_fail_count: assert property ((open_fail && !clr_q) |=>
    cnt_ofail_q == $past(cnt_ofail_q) + 32'h0000_0001)
    else $error("failed open not counted");
  a_clear_stats: assert property (clr_q |=> (cnt_open_q == '0 &&
    cnt_close_q == '0 && cnt_ofail_q == '0 && cnt_cfail_q == '0) ##1 !clr_q)
    else $error("statistics clear incomplete");
  a_cart_unused: assert property ((obj_type != OBJ_WD_BKR) |->
    cart_code == CART_UNUSED)
    else $error("cart status reported for non withdrawable object");
  a_bad_delay: assert property (($changed(bkr_code) &&
    bkr_code == POS_BAD) |-> $past(bkr_if.in_a && bkr_if.in_b))
    else $error("bad status without both inputs active");
  a_irq_follow: assert property (|(ist_q & imask_q) |=> irq_o)
    else $error("interrupt not raised for unmasked status");

endmodule // sgoc_top
`default_nettype wire

// ===== verif/sgoc_breaker_model.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------------
// Breaker contacts
// ---------------------------------------------------------------------
// Until a coil has been energised for DLY cycles both contacts read open circuit, so the
// contact inputs pass through the between state on every travel.
module sgoc_breaker_model #(
  parameter int DLY = 40
) (
  input wire logic clk_i,
  input wire logic open_cmd_i,
  input wire logic close_cmd_i,
  output logic open_st_o,
  output logic close_st_o
);
  int cnt = 0;
  initial begin
    open_st_o = 1'b0;
    close_st_o = 1'b1;
  end
  always @(posedge clk_i) begin
    if (open_cmd_i || close_cmd_i) begin
      cnt <= (cnt == DLY) ? cnt : cnt + 1;
      open_st_o <= open_cmd_i && cnt == DLY;
      close_st_o <= close_cmd_i && cnt == DLY;
    end else begin
      cnt <= 0;
    end
  end
endmodule // sgoc_breaker_model
`default_nettype wire

// ===== verif/switchgear_object_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module switchgear_object_control_tb;
  import sgoc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdat;
  logic ready_i = 1'b0, sync_ok_i = 1'b0, open_blk_i = 1'b0;
  logic cart_in_i = 1'b1;
  logic [2:0] req = 3'h0;
  logic open_st_i, close_st_i, open_cmd_o, close_cmd_o, irq_o;
  logic [31:0] exp_cnt [4] = '{32'h2, 32'h1, 32'h2, 32'h3};
  int num_errors = 0, compares = 0, cycles = 0;
  always #2 clk_i = ~clk_i;
  sgoc_top #(.CYC_MS(10)) DUT (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .open_st_i(open_st_i),
    .close_st_i(close_st_i), .cart_in_i(cart_in_i), .cart_out_i(1'b0),
    .ready_i(ready_i), .sync_ok_i(sync_ok_i), .loc_open_i(req[0]),
    .loc_close_i(req[1]), .open_blk_i(open_blk_i), .close_blk_i(1'b0),
    .auto_open_i(req[2]), .auto_close_i(1'b0), .open_cmd_o(open_cmd_o),
    .close_cmd_o(close_cmd_o), .irq_o(irq_o));
  sgoc_breaker_model PARTNER (.clk_i(clk_i), .open_cmd_i(open_cmd_o),
    .close_cmd_i(close_cmd_o), .open_st_o(open_st_i),
    .close_st_o(close_st_i));
  // ---------------------------------------------------------------------
  // Access and checking tasks
  // ---------------------------------------------------------------------
  task test_done;
    if (num_errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task bus(input logic we, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= wd;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] exp,
            input logic [31:0] msk, input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, rdat & msk, exp);
  endtask
  // Inputs are synchronised in the design, so a request waits for them.
  task pulse(input logic [2:0] m, input int n);
    repeat (3) @(posedge clk_i);
    req <= m;
    repeat (n) @(posedge clk_i);
    req <= 3'h0;
    repeat (8) @(posedge clk_i);
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      test_done;
    end
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk(ADR_CTRL, 32'h23, 32'hFFFFFFFF, "ctrl");
    rchk(ADR_STAT, 32'hF12, 32'hFFFF, "stat_closed");
    rchk(8'hFC, 32'h0, 32'hFFFFFFFF, "unmapped");
    bus(1'b1, ADR_IMASK, 32'h1);
    bus(1'b1, ADR_CMD, 32'h1);
    wait (open_cmd_o === 1'b1);
    wait (open_cmd_o === 1'b0);
    rchk(ADR_STAT, 32'hF11, 32'hFFFF, "stat_open");
    chk("irq_set", irq_o, 32'h1);
    bus(1'b1, ADR_IST, 32'hFF);
    repeat (2) @(posedge clk_i);
    chk("irq_clr", irq_o, 32'h0);
    pulse(3'h1, 4);
    bus(1'b1, ADR_CTRL, 32'h2);
    bus(1'b1, ADR_CMD, 32'h2);
    pulse(3'h2, 4);
    chk("ready_gate", close_cmd_o, 32'h0);
    ready_i <= 1'b1;
    bus(1'b1, ADR_CTRL, 32'hA);
    pulse(3'h2, 4);
    chk("sync_gate", close_cmd_o, 32'h0);
    sync_ok_i <= 1'b1;
    pulse(3'h2, 4);
    chk("close_cmd", close_cmd_o, 32'h1);
    wait (close_cmd_o === 1'b0);
    open_blk_i <= 1'b1;
    pulse(3'h4, 1);
    chk("open_blocked", open_cmd_o, 32'h0);
    open_blk_i <= 1'b0;
    pulse(3'h4, 1);
    chk("auto_open", open_cmd_o, 32'h1);
    wait (open_cmd_o === 1'b0);
    for (int i = 0; i < 4; i++) begin
      rchk(ADR_CNT_OPEN + 8'(4 * i), exp_cnt[i], 32'hFFFFFFFF, "cnt");
    end
    bus(1'b1, ADR_CMD, 32'h100);
    repeat (4) @(posedge clk_i);
    rchk(ADR_CMD, 32'h0, 32'h100, "clr_idle");
    for (int i = 0; i < 4; i++) begin
      rchk(ADR_CNT_OPEN + 8'(4 * i), 32'h0, 32'hFFFFFFFF, "cnt_clr");
    end
    // Remote, withdrawable, ready unused, single input, forced, select first.
    bus(1'b1, ADR_CTRL, 32'h1CE1);
    rchk(ADR_STAT, 32'hC009, 32'hF01F, "stat_forced");
    rchk(ADR_STAT, 32'h08, 32'h1C, "cart_in");
    bus(1'b1, ADR_CMD, 32'h1);
    rchk(ADR_CNT_OFAIL, 32'h1, 32'hFFFFFFFF, "sbe_refused");
    chk("sbe_no_open", open_cmd_o, 32'h0);
    bus(1'b1, ADR_CMD, 32'h8);
    rchk(ADR_CMD, 32'h8, 32'hC, "sel_close");
    bus(1'b1, ADR_CMD, 32'h2);
    chk("sbe_close", close_cmd_o, 32'h1);
    // The closed contact never closes here; only the open one is watched.
    repeat (8) @(posedge clk_i);
    rchk(ADR_STAT, 32'h2, 32'h3, "single_in");
    test_done;
  end
endmodule // switchgear_object_control_tb
`default_nettype wire
